/* src/mode_select_device.sv */
`timescale 1ns/1ns
module mode_select_device (
  input wire logic clk,
  input wire logic rst,
  mode_select_if.device pins,
  input wire logic flow_ctrl_en,
  input wire logic wireless_rx_event,
  input wire logic associated,
  input wire logic mode_switching,
  input wire logic upgrade_failed,
  input wire logic have_address,
  input wire logic ap_mode,
  input wire logic station_connected,
  input wire logic spi_irq,
  input wire logic data_tx_valid,
  input wire logic data_tx_bit,
  output logic startup_active,
  output logic upgrade_mode,
  output mode_select_pkg::if_mode_t if_mode,
  output logic power_save,
  output logic cts_ok,
  output logic spi_cs_active,
  output logic spi_clk,
  output logic spi_mosi
);
  import mode_select_pkg::*;
  logic rx_level, sel_level_s, cts_level, sclk_level, wake_level;
  logic [CNT_W-1:0] window_reg;
  logic [CNT_W-1:0] blink_reg;
  logic [15:0] baud_reg;
  logic [3:0] bit_reg;
  logic [9:0] shift_reg;
  logic [15:0] rx_baud_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_data_reg;
  logic rx_busy_reg;
  logic sel_low_seen_reg;
  logic blink_reg_phase;
  logic attention_reg;
  logic tx_reg;
  if_mode_t mode_reg;

  pin_sync sync_rx (.clk(clk), .rst(rst), .pin(pins.serial_rx), .level(rx_level));
  pin_sync sync_sel (.clk(clk), .rst(rst), .pin(pins.sel_level), .level(sel_level_s));
  pin_sync sync_cts (.clk(clk), .rst(rst), .pin(pins.cts_n), .level(cts_level));
  pin_sync sync_clk (.clk(clk), .rst(rst), .pin(pins.aux_clk), .level(sclk_level));
  pin_sync sync_wake (.clk(clk), .rst(rst), .pin(pins.wake_n), .level(wake_level));

  // Receiver: 8N1 at fixed baud, sampled mid-bit
  wire rx_start = !rx_busy_reg && !rx_level && startup_active;
  wire rx_mid = rx_busy_reg && (rx_baud_reg == 16'(BAUD_CYCLES / 2));
  wire rx_done = rx_mid && (rx_bit_reg == 4'h9);
  wire got_speedup = rx_done && rx_level && (rx_data_reg == SPEEDUP_CHAR);
  wire got_upgrade = rx_done && rx_level && (rx_data_reg == UPGRADE_CHAR);
  wire window_end = startup_active &&
    ((window_reg == CNT_W'(STARTUP_CYCLES - 1)) || got_speedup);
  // The window counter stops with the window, so it can never wrap

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_busy_reg <= 1'b0;
      rx_baud_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_data_reg <= 8'h00;
    end else if (rx_start) begin
      rx_busy_reg <= 1'b1;
      rx_baud_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
    end else if (rx_busy_reg) begin
      rx_baud_reg <= (rx_baud_reg == 16'(BAUD_CYCLES - 1)) ? 16'h0000 : rx_baud_reg + 16'h0001;
      if (rx_mid) begin
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg != 4'h0 && rx_bit_reg != 4'h9) begin
          rx_data_reg <= {rx_level, rx_data_reg[7:1]};
        end
        // A start bit that is high again at mid-bit was noise: drop it
        if (rx_done || (rx_bit_reg == 4'h0 && rx_level)) begin
          rx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // Start-up window, mode latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startup_active <= 1'b1;
      window_reg <= '0;
      sel_low_seen_reg <= 1'b0;
      mode_reg <= MODE_UART;
      upgrade_mode <= 1'b0;
    end else begin
      if (startup_active) begin
        window_reg <= window_reg + CNT_W'(1);
        if (!sel_level_s) begin
          sel_low_seen_reg <= 1'b1;
        end
        if (got_upgrade) begin
          upgrade_mode <= 1'b1;
        end
      end
      if (window_end) begin
        startup_active <= 1'b0;
        // Mode fixed here, a later low on the pin is ignored
        mode_reg <= (sel_low_seen_reg || !sel_level_s) ? MODE_SPI : MODE_UART;
      end
    end
  end
  assign if_mode = mode_reg;

  // Dot transmitter, repeating during the window
  wire baud_tick = (baud_reg == 16'(BAUD_CYCLES - 1));
  // A dot frame in flight is finished through its last data bit; its stop bit already goes out as tx_user
  wire dot_busy = (bit_reg != 4'h0);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= {1'b1, DOT_CHAR, 1'b0};
      tx_reg <= 1'b1;
    end else begin
      baud_reg <= baud_tick ? 16'h0000 : baud_reg + 16'h0001;
      if (baud_tick) begin
        if (startup_active || dot_busy) begin
          tx_reg <= shift_reg[0];
          shift_reg <= (bit_reg == 4'h9) ? {1'b1, DOT_CHAR, 1'b0} : {1'b1, shift_reg[9:1]};
          bit_reg <= (bit_reg == 4'h9) ? 4'h0 : bit_reg + 4'h1;
        end else begin
          tx_reg <= 1'b1;
          bit_reg <= 4'h0;
          shift_reg <= {1'b1, DOT_CHAR, 1'b0};
        end
      end
    end
  end

  // Serial out: dots, then user data; in SPI mode it is the MISO line
  wire tx_user = data_tx_valid ? data_tx_bit : 1'b1;
  assign pins.serial_tx = (startup_active || dot_busy) ? tx_reg : tx_user;

  // Shared pin: input during start-up, then IRQ or RTS
  wire spi_active = !startup_active && (mode_reg == MODE_SPI);
  wire rts_active = !startup_active && (mode_reg == MODE_UART) && flow_ctrl_en;
  assign pins.sel_dev_oe_n = !(spi_active || rts_active);
  // RTS sits low: the device always has room for host data
  assign pins.sel_dev_o = spi_active ? !spi_irq : 1'b0;

  assign cts_ok = (mode_reg == MODE_UART) && !startup_active &&
    (!flow_ctrl_en || !cts_level);
  assign spi_cs_active = spi_active && !cts_level;
  assign spi_clk = spi_active && sclk_level;
  assign spi_mosi = spi_active ? rx_level : 1'b0;
  assign power_save = wake_level;

  // Blink timer for failed upgrade
  // Free-running, so the phase is already defined when an upgrade fails
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_reg <= '0;
      blink_reg_phase <= 1'b0;
      attention_reg <= 1'b0;
    end else begin
      if (blink_reg == CNT_W'(BLINK_CYCLES - 1)) begin
        blink_reg <= '0;
        blink_reg_phase <= !blink_reg_phase;
      end else begin
        blink_reg <= blink_reg + CNT_W'(1);
      end
      // Held until the host wakes the device by pulling wake_n low
      if (wireless_rx_event) begin
        attention_reg <= 1'b1;
      end else if (!wake_level) begin
        attention_reg <= 1'b0;
      end
    end
  end

  wire ap_station = ap_mode && station_connected;
  wire link_on = (associated && !ap_mode) || mode_switching ||
    (upgrade_failed && blink_reg_phase) || ap_station;
  wire addr_on = have_address || ap_station;
  assign pins.link_indicator_n = !link_on;
  assign pins.address_indicator_n = !addr_on;
  assign pins.host_attention_n = !attention_reg;
endmodule : mode_select_device

/* src/mode_select_host.sv */
`timescale 1ns/1ns
module mode_select_host (
  input wire logic clk,
  input wire logic rst,
  mode_select_if.host pins,
  input wire logic want_spi,
  input wire logic send_speedup,
  input wire logic shutdown,
  input wire logic wake_req,
  input wire logic cts_n_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic select_done,
  output logic attention_seen
);
  import mode_select_pkg::*;
  typedef enum logic [1:0] {WAIT_DELAY, PULSE, DONE} sel_state_t;
  sel_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [15:0] baud_reg;
  logic [3:0] bit_reg;
  logic [9:0] shift_reg;
  logic sending_reg;
  logic att_level;

  pin_sync sync_att (.clk(clk), .rst(rst), .pin(pins.host_attention_n), .level(att_level));

  // Select pulse: wait past 50 ms, hold low 5..10 ms (aim at the middle)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= WAIT_DELAY;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        WAIT_DELAY: begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_W'(ASSERT_DELAY_CYCLES)) begin
            cnt_reg <= '0;
            state_reg <= want_spi ? PULSE : DONE;
          end
        end
        PULSE: begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_W'(PULSE_HOLD_CYCLES - 1)) begin
            state_reg <= DONE;
          end
        end
        DONE: cnt_reg <= '0;
        default: state_reg <= DONE;
      endcase
    end
  end
  assign pins.sel_host_oe_n = (state_reg != PULSE);
  assign pins.sel_host_o = 1'b0;
  assign select_done = (state_reg == DONE);

  // Speed-up character sender at 115200 baud
  wire baud_tick = (baud_reg == 16'(BAUD_CYCLES - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= UART_IDLE_FRAME;
      sending_reg <= 1'b0;
    end else if (!sending_reg) begin
      baud_reg <= 16'h0000;
      if (send_speedup) begin
        sending_reg <= 1'b1;
        shift_reg <= {1'b1, SPEEDUP_CHAR, 1'b0};
        bit_reg <= 4'h0;
      end
    end else begin
      baud_reg <= baud_tick ? 16'h0000 : baud_reg + 16'h0001;
      if (baud_tick) begin
        shift_reg <= {1'b1, shift_reg[9:1]};
        bit_reg <= bit_reg + 4'h1;
        if (bit_reg == 4'h9) begin
          sending_reg <= 1'b0;
        end
      end
    end
  end

  assign pins.serial_rx = (state_reg == DONE && want_spi) ? mosi_in : shift_reg[0];
  assign pins.cts_n = cts_n_in;
  assign pins.aux_clk = sclk_in;
  assign pins.wake_n = !wake_req;
  assign pins.power_enable_n = shutdown;
  assign attention_seen = !att_level;
endmodule : mode_select_host

/* src/mode_select_if.sv */
`timescale 1ns/1ns
interface mode_select_if;
  // Shared select / flow-control / interrupt pin, open for both to drive
  logic sel_dev_o;
  logic sel_dev_oe_n;
  logic sel_host_o;
  logic sel_host_oe_n;
  wire sel_level = (!sel_dev_oe_n) ? sel_dev_o : (!sel_host_oe_n) ? sel_host_o : 1'b1;
  logic serial_tx;
  logic serial_rx;
  logic cts_n;
  logic aux_clk;
  logic wake_n;
  logic host_attention_n;
  logic link_indicator_n;
  logic address_indicator_n;
  logic power_enable_n;
  modport device (output sel_dev_o, output sel_dev_oe_n, input sel_level,
    output serial_tx, input serial_rx, input cts_n, input aux_clk, input wake_n,
    output host_attention_n, output link_indicator_n, output address_indicator_n,
    input power_enable_n);
  modport host (output sel_host_o, output sel_host_oe_n, input sel_level,
    input serial_tx, output serial_rx, output cts_n, output aux_clk, output wake_n,
    input host_attention_n, input link_indicator_n, input address_indicator_n,
    output power_enable_n);
endinterface : mode_select_if

/* src/mode_select_pkg.sv */
package mode_select_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  // Times in their printed units
  localparam int unsigned STARTUP_WINDOW_S = 5;
  localparam int unsigned SELECT_ASSERT_DELAY_MS = 50;
  localparam int unsigned SELECT_PULSE_WIDTH_MIN_MS = 5;
  localparam int unsigned SELECT_PULSE_WIDTH_MAX_MS = 10;
  localparam int unsigned BLINK_INTERVAL_S = 2;
  localparam int unsigned BAUD = 115200;
  // Cycle counts derived from the clock rate
  localparam longint unsigned STARTUP_CYCLES = longint'(STARTUP_WINDOW_S) * CLK_HZ;
  localparam longint unsigned ASSERT_DELAY_CYCLES =
    (longint'(SELECT_ASSERT_DELAY_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned PULSE_MIN_CYCLES =
    (longint'(SELECT_PULSE_WIDTH_MIN_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned PULSE_MAX_CYCLES =
    longint'(SELECT_PULSE_WIDTH_MAX_MS) * CLK_HZ / 1000;
  localparam longint unsigned PULSE_HOLD_CYCLES = (PULSE_MIN_CYCLES + PULSE_MAX_CYCLES) / 2;
  localparam longint unsigned BLINK_CYCLES = longint'(BLINK_INTERVAL_S) * CLK_HZ;
  localparam int unsigned BAUD_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned CNT_W = 32;
  localparam logic [7:0] DOT_CHAR = 8'h2E;
  localparam logic [7:0] SPEEDUP_CHAR = 8'h77;
  localparam logic [7:0] UPGRADE_CHAR = 8'h75;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam logic [9:0] UART_IDLE_FRAME = 10'h3FF;
  typedef enum logic {MODE_UART, MODE_SPI} if_mode_t;
endpackage : mode_select_pkg

/* src/pin_sync.sv */
`timescale 1ns/1ns
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  import mode_select_pkg::*;
  logic [2:0] stage_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_reg <= SYNC_RESET;
      level <= 1'b1;
    end else begin
      stage_reg <= {stage_reg[1:0], pin};
      // Only the two later stages are compared
      if (stage_reg[1] == stage_reg[2]) begin
        level <= stage_reg[2];
      end
    end
  end
endmodule : pin_sync

/* tb/host_interface_mode_select_tb.sv */
`timescale 1ns/1ns
module host_interface_mode_select_tb;
  import mode_select_pkg::*;
  logic clk, rst, flow_ctrl_en, wireless_rx_event, associated, mode_switching;
  logic upgrade_failed, have_address, ap_mode, station_connected, spi_irq;
  logic send_speedup, shutdown, wake_req, cts_n_in;
  logic startup_active, upgrade_mode, power_save, cts_ok, attention_seen;
  logic select_done, spi_cs_active, spi_clk, spi_mosi;
  if_mode_t if_mode;
  int fail_count, checks_done;
  logic [7:0] rx_byte;
  // Columns: associated, switching, address, ap, station, link_n, address_n
  logic [6:0] rows [0:6] = '{7'h03, 7'h41, 7'h21, 7'h12, 7'h0B, 7'h0C, 7'h07};

  mode_select_if ms_if();
  wire [1:0] lamps_n = {ms_if.link_indicator_n, ms_if.address_indicator_n};
  mode_select_device u_mode_select_device (.clk(clk), .rst(rst), .pins(ms_if),
    .flow_ctrl_en(flow_ctrl_en), .wireless_rx_event(wireless_rx_event),
    .associated(associated), .mode_switching(mode_switching),
    .upgrade_failed(upgrade_failed), .have_address(have_address), .ap_mode(ap_mode),
    .station_connected(station_connected), .spi_irq(spi_irq), .data_tx_valid(1'b0),
    .data_tx_bit(1'b0), .startup_active(startup_active), .upgrade_mode(upgrade_mode),
    .if_mode(if_mode), .power_save(power_save), .cts_ok(cts_ok),
    .spi_cs_active(spi_cs_active), .spi_clk(spi_clk), .spi_mosi(spi_mosi));
  mode_select_host u_mode_select_host (.clk(clk), .rst(rst), .pins(ms_if), .want_spi(1'b0),
    .send_speedup(send_speedup), .shutdown(shutdown), .wake_req(wake_req),
    .cts_n_in(cts_n_in), .sclk_in(1'b0), .mosi_in(1'b0), .select_done(select_done),
    .attention_seen(attention_seen));
  mode_select_props u_mode_select_props (.clk(clk), .rst(rst),
    .sel_dev_oe_n(ms_if.sel_dev_oe_n), .sel_host_oe_n(ms_if.sel_host_oe_n),
    .sel_level(ms_if.sel_level), .serial_tx(ms_if.serial_tx), .wake_n(ms_if.wake_n),
    .host_attention_n(ms_if.host_attention_n));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #(80000 * 8);
    fail_count++;
    results();
  end

  initial begin
    {rst, flow_ctrl_en, wireless_rx_event, associated, mode_switching} = 5'h10;
    {upgrade_failed, have_address, ap_mode, station_connected, spi_irq} = 5'h00;
    {send_speedup, shutdown, wake_req, cts_n_in} = 4'h1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      {associated, mode_switching, have_address, ap_mode, station_connected} <= rows[i][6:2];
      @(negedge clk);
      chk(8'(lamps_n), 8'(rows[i][1:0]));
    end
    @(negedge clk);
    chk(8'(startup_active), 8'h01);
    chk(8'(if_mode), 8'(MODE_UART));
    chk(8'(ms_if.host_attention_n), 8'h01);
    for (int n = 0; n < 3000 && ms_if.serial_tx !== 1'b0; n++) @(negedge clk);
    repeat (BAUD_CYCLES / 2) @(negedge clk);
    chk(8'(ms_if.serial_tx), 8'h00);
    for (int b = 0; b < 8; b++) begin
      repeat (BAUD_CYCLES) @(negedge clk);
      rx_byte = {ms_if.serial_tx, rx_byte[7:1]};
    end
    chk(rx_byte, DOT_CHAR);
    repeat (BAUD_CYCLES) @(negedge clk);
    chk(8'(ms_if.serial_tx), 8'h01);
    // Flow control asked for while the window still runs must not take the pin yet
    @(posedge clk);
    flow_ctrl_en <= 1'b1;
    send_speedup <= 1'b1;
    @(posedge clk);
    send_speedup <= 1'b0;
    repeat (6) @(negedge clk);
    chk(8'(ms_if.sel_dev_oe_n), 8'h01);
    for (int n = 0; n < 20000 && startup_active !== 1'b0; n++) @(negedge clk);
    chk(8'(startup_active), 8'h00);
    chk(8'(if_mode), 8'(MODE_UART));
    chk(8'(upgrade_mode), 8'h00);
    repeat (6) @(negedge clk);
    chk(8'({ms_if.sel_dev_oe_n, ms_if.sel_level, cts_ok}), 8'h00);
    chk(8'({select_done, ms_if.sel_host_oe_n}), 8'h01);
    @(posedge clk);
    flow_ctrl_en <= 1'b0;
    repeat (6) @(negedge clk);
    chk(8'({ms_if.sel_dev_oe_n, ms_if.sel_level, cts_ok}), 8'h07);
    // Flow control on with CTS asserted; the SPI side must stay dead in UART mode
    @(posedge clk);
    flow_ctrl_en <= 1'b1;
    cts_n_in <= 1'b0;
    repeat (6) @(negedge clk);
    chk(8'({cts_ok, spi_cs_active, spi_clk, spi_mosi}), 8'h08);
    @(posedge clk);
    wireless_rx_event <= 1'b1;
    @(posedge clk);
    wireless_rx_event <= 1'b0;
    repeat (6) @(negedge clk);
    chk(8'({ms_if.host_attention_n, attention_seen}), 8'h01);
    @(posedge clk);
    wake_req <= 1'b1;
    shutdown <= 1'b1;
    repeat (8) @(negedge clk);
    chk(8'({power_save, ms_if.host_attention_n, ms_if.power_enable_n}), 8'h03);
    @(posedge clk);
    wake_req <= 1'b0;
    shutdown <= 1'b0;
    repeat (8) @(negedge clk);
    chk(8'({power_save, ms_if.power_enable_n}), 8'h02);
    // A second reset must reopen the window and hand the pin back
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(8'({startup_active, ms_if.sel_dev_oe_n}), 8'h03);
    repeat (2) @(negedge clk);
    chk(8'({ms_if.serial_tx, ms_if.host_attention_n}), 8'h03);
    results();
  end
endmodule : host_interface_mode_select_tb

/* tb/mode_select_props.sv */
`timescale 1ns/1ns
module mode_select_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_dev_oe_n,
  input wire logic sel_host_oe_n,
  input wire logic sel_level,
  input wire logic serial_tx,
  input wire logic wake_n,
  input wire logic host_attention_n
);
  logic [13:0] since_rst_reg;
  logic [10:0] tx_gap_reg;
  logic tx_last_reg;
  logic [2:0] wake_high_reg;
  // Counters saturate so a long run never wraps back into the early window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_rst_reg <= 14'h0000;
      tx_gap_reg <= 11'h7FF;
      tx_last_reg <= 1'b1;
      wake_high_reg <= 3'h0;
    end else begin
      since_rst_reg <= (since_rst_reg == 14'h3FFF) ? since_rst_reg : since_rst_reg + 14'h0001;
      tx_last_reg <= serial_tx;
      tx_gap_reg <= (serial_tx != tx_last_reg) ? 11'h000 :
        (tx_gap_reg == 11'h7FF) ? tx_gap_reg : tx_gap_reg + 11'h001;
      wake_high_reg <= !wake_n ? 3'h0 :
        (wake_high_reg == 3'h7) ? wake_high_reg : wake_high_reg + 3'h1;
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  release_idle_a: assert property ($fell(rst) |->
    serial_tx && sel_dev_oe_n && host_attention_n)
    else $error("pins not idle after reset");
  sel_pullup_a: assert property (sel_dev_oe_n && sel_host_oe_n |-> sel_level)
    else $error("undriven select pin not high");
  no_contention_a: assert property (!sel_dev_oe_n |-> sel_host_oe_n)
    else $error("both ends drive the select pin");
  early_dev_a: assert property (since_rst_reg < 14'h2710 |-> sel_dev_oe_n)
    else $error("device drives select pin during start-up");
  early_host_a: assert property (since_rst_reg < 14'h2710 |-> sel_host_oe_n)
    else $error("host drives select pin too early");
  start_bit_a: assert property ($fell(serial_tx) |=> !serial_tx [*8])
    else $error("start bit too short");
  bit_time_a: assert property ($fell(serial_tx) |-> tx_gap_reg >= 11'h43C)
    else $error("serial bit shorter than one baud period");
  attention_hold_a: assert property (!host_attention_n && wake_high_reg == 3'h7 |=>
    !host_attention_n)
    else $error("attention released without wake");
endmodule : mode_select_props
